// file: rtl/diag_executive.sv
// inline diagnostic executive: idle exit, fetch/execute sequencing, operator buffer
`timescale 1ns/1ps
// Contract
// - kernel id is 12 bits: upper 8 kernel number, lower 4 section
// - leave idle only if unselected, nothing pending, halt latch clear
// - after exit, diag enable on runs executive, else buffer operation
// - not loaded: take program drive from slot 1, load if offline
// - after load, init writes id to slot 2, sets loaded, returns idle
// - loaded: check test drive of slot 0 offline, then execute
// - maintenance mode set on idle exit, cleared on idle re-entry
// - loaded flag set by init, cleared after execute unless looping without rewind kernel
// - buffer holds 16 positions of 12 bits, data, parity, three controls
// - rewind kernel rewinds if slot 1 ctl_bit_three, else sets halt
// - slot 2 holds kernel id; copied to display when not executing
// - slot 3 ctl_bit_three loops kernel; with ctl_bit_two loops test
// - with ctl_bit_three clear, ctl_bit_one/two select normal, space, search
// - search forward only, match number ignoring section, stop on first
// - space and search run no tests but update display per kernel
// - success exit copies id to display, clears loaded unless looping without rewind kernel, returns idle
// - failure exit sets fail flag, copies scratch bits 0-7 to slot 3
// - after failure, not looping sets halt; looping skips halt
// - looping clears fail flag each pass, sets on failing pass
// - kernels fetched ascending; section f only after a start press
// - start clears halt latch; stop sets halt latch
// - priority delay after host op blocks maintenance exit until expiry
module diag_executive
	import diag_exec_pkg::*;
#(
	parameter int DELAY_W = 16
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// register port
	input wire logic [4:0] reg_addr_i,
	input wire logic [11:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [11:0] reg_rdata_o,
	// operator panel
	input wire logic diag_enable_i,
	input wire logic start_press_i,
	input wire logic stop_press_i,
	input wire logic [1:0] priority_sel_i,
	output logic halt_ind_o,
	output logic fail_ind_o,
	output logic [11:0] maint_display_register_o,
	// host side status
	input wire logic host_selected_i,
	input wire logic host_pending_i,
	input wire logic host_op_done_i,
	// tape drives
	input wire logic drive_offline_i,
	output logic [7:0] drive_addr_o,
	output logic load_order_o,
	input wire logic load_done_i,
	output logic rewind_order_o,
	output logic tape_move_o,
	input wire logic kernel_passed_i,
	input wire logic [11:0] passed_id_i,
	// kernel code store
	output logic init_start_o,
	input wire logic init_done_i,
	input wire logic [11:0] init_kernel_id_i,
	output logic exec_start_o,
	output logic loop_test_o,
	input wire kernel_result_s result_i,
	input wire logic [7:0] scratch_fail_i,
	// state
	output logic maint_mode_o,
	output logic busy_o
);

	////////////////////////////////////////////////////////////////////////
	// storage

	logic [BUF_WIDTH-1:0] maint_scratch_buffer [BUF_DEPTH];
	exec_state_e state;
	exec_state_e next_state;
	logic kernel_loaded_flag;
	logic test_fail_flag;
	logic halt_latch;
	logic maint_mode;
	logic [7:0] drive_addr;
	logic [11:0] display;
	logic [7:0] general_scratch_register;
	logic manual_armed;
	logic delay_expired;
	logic [DELAY_W-1:0] delay_value;
	logic [11:0] rdata;

	kernel_id_s cur_id;
	logic req_loop;
	logic req_loop_test;
	op_request_e req_code;
	logic rewind_opt;
	logic idle_exit;
	logic searching;
	logic search_hit;

	assign cur_id = kernel_id_s'(maint_scratch_buffer[POS_KERNEL_ID]);
	assign req_loop = maint_scratch_buffer[POS_OPERATOR_REQ][FLD_CTL_THREE];
	assign req_loop_test = req_loop && maint_scratch_buffer[POS_OPERATOR_REQ][FLD_CTL_TWO];
	assign req_code = op_request_e'({maint_scratch_buffer[POS_OPERATOR_REQ][FLD_CTL_ONE],
		maint_scratch_buffer[POS_OPERATOR_REQ][FLD_CTL_TWO]});
	assign rewind_opt = maint_scratch_buffer[POS_PROGRAM_DRIVE][FLD_CTL_THREE];
	assign searching = !req_loop && (req_code == REQ_SPACE || req_code == REQ_SEARCH);
	assign search_hit = (req_code == REQ_SEARCH) &&
		(passed_id_i[11:4] == maint_scratch_buffer[POS_OPERATOR_REQ][FLD_DATA_HI:FLD_DATA_LO]);

	////////////////////////////////////////////////////////////////////////
	// priority delay

	always_comb begin
		case (priority_sel_i)
			2'd0: delay_value = DELAY_W'(PRIO_DELAY_1);
			2'd1: delay_value = DELAY_W'(PRIO_DELAY_2);
			2'd2: delay_value = DELAY_W'(PRIO_DELAY_3);
			default: delay_value = DELAY_W'(PRIO_DELAY_4);
		endcase
	end

	delay_counter #(
		.WIDTH(DELAY_W)
	) u_delay (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.load_i(host_op_done_i),
		.value_i(delay_value),
		.tick_i(state == ST_IDLE),
		.expired_o(delay_expired)
	);

	// exit qualification; section f needs a start press
	assign idle_exit = (state == ST_IDLE) && !host_selected_i && !host_pending_i &&
		!halt_latch && delay_expired && !host_op_done_i &&
		(!kernel_loaded_flag || cur_id.section != SECTION_MANUAL || manual_armed ||
		start_press_i);

	////////////////////////////////////////////////////////////////////////
	// sequencer

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (idle_exit) begin
					next_state = ST_DISPATCH;
				end
			end
			ST_DISPATCH: begin
				if (!diag_enable_i) begin
					next_state = ST_BUF_OP;
				end else if (kernel_loaded_flag && !searching) begin
					next_state = ST_EXEC_CHK;
				end else begin
					next_state = ST_FETCH_CHK;
				end
			end
			ST_FETCH_CHK: begin
				next_state = drive_offline_i ? ST_LOADING : ST_RETURN;
			end
			ST_LOADING: begin
				if (searching && kernel_passed_i) begin
					next_state = ST_RETURN;
				end else if (load_done_i) begin
					next_state = ST_INIT;
				end
			end
			ST_INIT: begin
				if (init_done_i) begin
					next_state = ST_RETURN;
				end
			end
			ST_EXEC_CHK: begin
				next_state = drive_offline_i ? ST_EXECUTE : ST_RETURN;
			end
			ST_EXECUTE: begin
				if (result_i.done) begin
					next_state = ST_RETURN;
				end
			end
			ST_BUF_OP: next_state = ST_RETURN;
			ST_RETURN: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// flags

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			maint_mode <= 1'b0;
		end else if (state == ST_RETURN) begin
			maint_mode <= 1'b0;
		end else if (idle_exit) begin
			maint_mode <= 1'b1;
		end
	end

	// loaded flag set by init, cleared after non-looping or rewind-kernel pass
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			kernel_loaded_flag <= 1'b0;
		end else if (state == ST_INIT && init_done_i) begin
			kernel_loaded_flag <= 1'b1;
		end else if (state == ST_EXECUTE && result_i.done && (!req_loop || result_i.rewind_kernel)) begin
			kernel_loaded_flag <= 1'b0;
		end
	end

	// fail flag cleared per looping pass; set on failure
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			test_fail_flag <= 1'b0;
		end else if (state == ST_EXECUTE && result_i.done && result_i.fail) begin
			test_fail_flag <= 1'b1;
		end else if (state == ST_EXEC_CHK && drive_offline_i && req_loop) begin
			test_fail_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			halt_latch <= 1'b0;
		end else if (stop_press_i) begin
			halt_latch <= 1'b1;
		end else if (state == ST_EXECUTE && result_i.done && result_i.fail && !req_loop) begin
			halt_latch <= 1'b1;
		end else if (state == ST_EXECUTE && result_i.done && result_i.rewind_kernel && !rewind_opt) begin
			halt_latch <= 1'b1;
		end else if (state == ST_LOADING && searching && search_hit && kernel_passed_i) begin
			halt_latch <= 1'b1;
		end else if (start_press_i) begin
			halt_latch <= 1'b0;
		end
	end

	// manual section held until a start press
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			manual_armed <= 1'b0;
		end else if (start_press_i) begin
			manual_armed <= 1'b1;
		end else if (state == ST_RETURN) begin
			manual_armed <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// drive address, scratch, display

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			drive_addr <= RST_DRIVE;
		end else if (state == ST_DISPATCH && diag_enable_i) begin
			if (kernel_loaded_flag && !searching) begin
				drive_addr <= maint_scratch_buffer[POS_TEST_DRIVE][FLD_DATA_HI:FLD_DATA_LO];
			end else begin
				drive_addr <= maint_scratch_buffer[POS_PROGRAM_DRIVE][FLD_DATA_HI:FLD_DATA_LO];
			end
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			general_scratch_register <= 8'h00;
		end else if (state == ST_EXECUTE && result_i.fail) begin
			general_scratch_register <= scratch_fail_i;
		end
	end

	// display when idle; passing ids; success copy
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			display <= RST_SLOT;
		end else if (state == ST_LOADING && kernel_passed_i) begin
			display <= passed_id_i;
		end else if (state != ST_EXECUTE) begin
			display <= maint_scratch_buffer[POS_KERNEL_ID];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// buffer and register port

	// id into slot 2; failure data into slot 3
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < BUF_DEPTH; i++) begin
				maint_scratch_buffer[i] <= RST_SLOT;
			end
		end else begin
			if (reg_wr_i && !reg_addr_i[4]) begin
				maint_scratch_buffer[reg_addr_i[3:0]] <= reg_wdata_i;
			end
			if (state == ST_INIT && init_done_i) begin
				maint_scratch_buffer[POS_KERNEL_ID] <= init_kernel_id_i;
			end
			if (state == ST_LOADING && kernel_passed_i) begin
				maint_scratch_buffer[POS_KERNEL_ID] <= passed_id_i;
			end
			if (state == ST_EXECUTE && result_i.done && result_i.fail) begin
				maint_scratch_buffer[POS_OPERATOR_REQ][FLD_DATA_HI:FLD_DATA_LO] <= scratch_fail_i;
			end
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rdata <= 12'h000;
		end else if (reg_rd_i) begin
			if (!reg_addr_i[4]) begin
				rdata <= maint_scratch_buffer[reg_addr_i[3:0]];
			end else begin
				case (reg_addr_i)
					REG_STATUS: rdata <= {7'h00, state != ST_IDLE, maint_mode, halt_latch,
						test_fail_flag, kernel_loaded_flag};
					REG_DISPLAY: rdata <= display;
					REG_SCRATCH: rdata <= {4'h0, general_scratch_register};
					REG_DRIVE_ADDR: rdata <= {4'h0, drive_addr};
					default: rdata <= 12'h000;
				endcase
			end
		end else begin
			rdata <= 12'h000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign reg_rdata_o = rdata;
	assign halt_ind_o = halt_latch;
	assign fail_ind_o = test_fail_flag;
	assign maint_display_register_o = display;
	assign drive_addr_o = drive_addr;
	assign load_order_o = (state == ST_FETCH_CHK) && drive_offline_i && !searching;
	assign tape_move_o = (state == ST_FETCH_CHK) && drive_offline_i && searching;
	assign rewind_order_o = (state == ST_EXECUTE) && result_i.done && result_i.rewind_kernel && rewind_opt;
	assign init_start_o = (state == ST_LOADING) && load_done_i && !searching;
	assign exec_start_o = (state == ST_EXEC_CHK) && drive_offline_i;
	assign loop_test_o = req_loop_test;
	assign maint_mode_o = maint_mode;
	assign busy_o = (state != ST_IDLE);

endmodule : diag_executive

// file: rtl/diag_exec_pkg.sv
// shared constants and types for the inline diagnostic executive
package diag_exec_pkg;

	// maint_scratch_buffer geometry: 16 positions of 12 bits
	localparam int BUF_DEPTH = 16;
	localparam int BUF_WIDTH = 12;
	localparam int BUF_AW = 4;

	// field positions inside a buffer position, bit 0 is the rightmost (lsb)
	localparam int FLD_DATA_HI = 11;
	localparam int FLD_DATA_LO = 4;
	localparam int FLD_PARITY = 3;
	localparam int FLD_CTL_ONE = 2;
	localparam int FLD_CTL_TWO = 1;
	localparam int FLD_CTL_THREE = 0;

	// buffer positions used by the executive
	localparam logic [3:0] POS_TEST_DRIVE = 4'h0;
	localparam logic [3:0] POS_PROGRAM_DRIVE = 4'h1;
	localparam logic [3:0] POS_KERNEL_ID = 4'h2;
	localparam logic [3:0] POS_OPERATOR_REQ = 4'h3;

	// register port offsets: buffer positions 0..15 then status/control
	localparam logic [4:0] REG_BUF_BASE = 5'h00;
	localparam logic [4:0] REG_STATUS = 5'h10;
	localparam logic [4:0] REG_DISPLAY = 5'h11;
	localparam logic [4:0] REG_SCRATCH = 5'h12;
	localparam logic [4:0] REG_DRIVE_ADDR = 5'h13;

	// status bit positions
	localparam int ST_KERNEL_LOADED = 0;
	localparam int ST_TEST_FAIL = 1;
	localparam int ST_HALT = 2;
	localparam int ST_MAINT_MODE = 3;
	localparam int ST_BUSY = 4;

	// reset values
	localparam logic [11:0] RST_SLOT = 12'h000;
	localparam logic [7:0] RST_DRIVE = 8'h00;

	// section bounds for the automatic sequence
	localparam logic [3:0] SECTION_FIRST = 4'h1;
	localparam logic [3:0] SECTION_LAST_AUTO = 4'he;
	localparam logic [3:0] SECTION_MANUAL = 4'hf;

	// priority delay counts per switch position 1..4 (cycles)
	localparam logic [15:0] PRIO_DELAY_1 = 16'h0010;
	localparam logic [15:0] PRIO_DELAY_2 = 16'h0100;
	localparam logic [15:0] PRIO_DELAY_3 = 16'h0400;
	localparam logic [15:0] PRIO_DELAY_4 = 16'h1000;

	// operator request codes from ctl_bit_one/ctl_bit_two
	typedef enum logic [1:0] {
		REQ_NORMAL = 2'b00,
		REQ_SPACE = 2'b01,
		REQ_RESERVED = 2'b10,
		REQ_SEARCH = 2'b11
	} op_request_e;

	typedef enum logic [8:0] {
		ST_IDLE = 9'b000000001,
		ST_DISPATCH = 9'b000000010,
		ST_FETCH_CHK = 9'b000000100,
		ST_LOADING = 9'b000001000,
		ST_INIT = 9'b000010000,
		ST_EXEC_CHK = 9'b000100000,
		ST_EXECUTE = 9'b001000000,
		ST_BUF_OP = 9'b010000000,
		ST_RETURN = 9'b100000000
	} exec_state_e;

	// 12-bit kernel identifier: kernel number high, section low
	typedef struct packed {
		logic [7:0] number;
		logic [3:0] section;
	} kernel_id_s;

	// register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [4:0] addr;
		logic [11:0] wdata;
	} reg_req_s;

	// kernel outcome reported back by the kernel code
	typedef struct packed {
		logic done;
		logic fail;
		logic rewind_kernel;
		logic [7:0] fail_data;
	} kernel_result_s;

endpackage : diag_exec_pkg

// file: rtl/delay_counter.sv
// priority delay down-counter
`timescale 1ns/1ps
module delay_counter
	import diag_exec_pkg::*;
#(
	parameter int WIDTH = 16
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// control
	input wire logic load_i,
	input wire logic [WIDTH-1:0] value_i,
	input wire logic tick_i,
	// status
	output logic expired_o
);

	logic [WIDTH-1:0] count;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			count <= '0;
		end else if (load_i) begin
			count <= value_i;
		end else if (tick_i && count != '0) begin
			count <= count - 1'b1;
		end
	end

	assign expired_o = (count == '0);

endmodule : delay_counter

// file: dv/diag_executive_monitor.sv
// port-level assertions for the diagnostic executive
`timescale 1ns/1ps
module diag_executive_monitor
	import diag_exec_pkg::*;
#(
	parameter int DELAY_W = 16
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// host and panel
	input wire logic host_selected_i,
	input wire logic host_pending_i,
	input wire logic host_op_done_i,
	input wire logic start_press_i,
	input wire logic halt_ind_o,
	input wire logic fail_ind_o,
	input wire logic [11:0] maint_display_register_o,
	// drives and kernel
	input wire logic drive_offline_i,
	input wire logic load_order_o,
	input wire logic exec_start_o,
	input wire logic kernel_passed_i,
	input wire logic [11:0] passed_id_i,
	input wire kernel_result_s result_i,
	// state
	input wire logic maint_mode_o,
	input wire logic busy_o
);
	logic [11:0] last_id;
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			last_id <= 12'h000;
		end else if (kernel_passed_i) begin
			last_id <= passed_id_i;
		end
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	host_gate_a: assert property (!busy_o && (host_selected_i || host_pending_i) |=> !busy_o)
		else $error("left idle while host busy");
	halt_gate_a: assert property (!busy_o && halt_ind_o && !start_press_i |=> !busy_o)
		else $error("left idle while halted");
	maint_clear_a: assert property ($fell(busy_o) |-> !maint_mode_o)
		else $error("maintenance mode kept in idle");
	maint_set_a: assert property ($rose(busy_o) |-> ##[0:1] maint_mode_o)
		else $error("maintenance mode not set on exit");
	load_offline_a: assert property (load_order_o |-> drive_offline_i && busy_o)
		else $error("load order to online drive");
	exec_offline_a: assert property (exec_start_o |-> drive_offline_i)
		else $error("execution on online drive");
	fail_flag_a: assert property (busy_o && result_i.done && result_i.fail |=> fail_ind_o)
		else $error("fail flag not set");
	success_ret_a: assert property (busy_o && result_i.done && !result_i.fail |-> ##[1:3] !busy_o)
		else $error("no return after success");
	prio_delay_a: assert property (!busy_o && host_op_done_i |=> !busy_o [*8])
		else $error("exit inside priority delay");
	pass_display_a: assert property (busy_o && kernel_passed_i |-> ##[1:2] maint_display_register_o == last_id)
		else $error("display not following passed kernel");
endmodule : diag_executive_monitor
bind diag_executive diag_executive_monitor #(.DELAY_W(DELAY_W)) monitor (.*);

// file: dv/diag_far_side_model.sv
// tape drives and kernel code answering the executive
`timescale 1ns/1ps
module diag_far_side_model
	import diag_exec_pkg::*;
#(
	parameter int LAT = 3
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// orders from the executive
	input wire logic load_order_i,
	input wire logic init_start_i,
	input wire logic exec_start_i,
	input wire logic tape_move_i,
	// scenario controls
	input wire logic offline_set_i,
	input wire logic fail_set_i,
	input wire logic rewind_set_i,
	input wire logic [11:0] kernel_id_i,
	input wire logic [7:0] fail_data_i,
	// answers
	output logic drive_offline_o,
	output logic load_done_o,
	output logic init_done_o,
	output logic kernel_passed_o,
	output logic [11:0] id_o,
	output kernel_result_s result_o,
	output logic [7:0] scratch_o
);
	logic [3:0] wait_cnt;
	logic [1:0] kind;
	logic active;
	logic done_r;
	assign drive_offline_o = offline_set_i;
	// id valid only with its pulse, inverted otherwise
	assign id_o = (init_done_o || kernel_passed_o) ? kernel_id_i : ~kernel_id_i;
	assign scratch_o = fail_data_i;
	assign result_o = '{done_r, done_r & fail_set_i, done_r & rewind_set_i, done_r ? fail_data_i : 8'h00};
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			{active, done_r, load_done_o, init_done_o, kernel_passed_o} <= 5'h00;
			wait_cnt <= 4'h0;
			kind <= 2'h0;
		end else begin
			{done_r, load_done_o, init_done_o, kernel_passed_o} <= 4'h0;
			if (load_order_i || init_start_i || exec_start_i || tape_move_i) begin
				active <= 1'b1;
				wait_cnt <= 4'(LAT);
				kind <= init_start_i ? 2'h1 : exec_start_i ? 2'h2 : tape_move_i ? 2'h3 : 2'h0;
			end else if (active && wait_cnt == 4'h0) begin
				active <= 1'b0;
				load_done_o <= (kind == 2'h0);
				init_done_o <= (kind == 2'h1);
				done_r <= (kind == 2'h2);
				kernel_passed_o <= (kind == 2'h3);
			end else if (active) begin
				wait_cnt <= wait_cnt - 4'h1;
			end
		end
	end
endmodule : diag_far_side_model

// file: dv/tb_diag_executive.sv
// register-level testbench for the diagnostic executive
`timescale 1ns/1ps
module tb_diag_executive
	import diag_exec_pkg::*;
;
	logic clk_sys_i, rst_i, reg_wr_i, reg_rd_i, diag_enable_i, start_press_i, stop_press_i;
	logic host_selected_i, host_pending_i, host_op_done_i, drive_offline_i, load_done_i;
	logic kernel_passed_i, init_done_i, halt_ind_o, fail_ind_o, load_order_o, rewind_order_o;
	logic tape_move_o, init_start_o, exec_start_o, loop_test_o, maint_mode_o, busy_o;
	logic [4:0] reg_addr_i;
	logic [11:0] reg_wdata_i, reg_rdata_o, maint_display_register_o, passed_id_i, init_kernel_id_i, kid, v;
	logic [1:0] priority_sel_i;
	logic [7:0] drive_addr_o, scratch_fail_i, fdata;
	logic offline_set, fail_set, rew_set;
	kernel_result_s result_i;
	int num_errors, total_checks, load_cnt, exec_cnt, rew_cnt, e;
	diag_executive dut (.*);
	diag_far_side_model model (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .load_order_i(load_order_o),
		.init_start_i(init_start_o), .exec_start_i(exec_start_o), .tape_move_i(tape_move_o),
		.offline_set_i(offline_set), .fail_set_i(fail_set), .rewind_set_i(rew_set), .kernel_id_i(kid),
		.fail_data_i(fdata),
		.drive_offline_o(drive_offline_i), .load_done_o(load_done_i), .init_done_o(init_done_i),
		.kernel_passed_o(kernel_passed_i), .id_o(passed_id_i), .result_o(result_i), .scratch_o(scratch_fail_i));
	assign init_kernel_id_i = passed_id_i;
	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		load_cnt += (load_order_o === 1'b1);
		exec_cnt += (exec_start_o === 1'b1);
		rew_cnt += (rewind_order_o === 1'b1);
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [11:0] d);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	task automatic rdchk(input logic [4:0] a, input logic [11:0] m, input logic [11:0] x);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		#1 v = reg_rdata_o;
		chk(v & m, x);
	endtask : rdchk
	task automatic wait_busy(input logic val, input int n);
		for (int k = 0; k < n && busy_o !== val; k++) begin
			@(posedge clk_sys_i);
			#1;
		end
		chk({11'h000, busy_o}, {11'h000, val});
	endtask : wait_busy
	// one idle exit with the host released, host taken back once idle again
	task automatic step();
		@(posedge clk_sys_i);
		host_selected_i <= 1'b0;
		start_press_i <= 1'b1;
		@(posedge clk_sys_i);
		start_press_i <= 1'b0;
		#1 wait_busy(1'b1, 40);
		wait_busy(1'b0, 80);
		host_selected_i <= 1'b1;
	endtask : step
	task automatic press(input logic stop);
		@(posedge clk_sys_i);
		stop_press_i <= stop;
		start_press_i <= !stop;
		@(posedge clk_sys_i);
		{stop_press_i, start_press_i} <= 2'b00;
		@(posedge clk_sys_i);
		#1;
	endtask : press
	task end_sim;
		$display("total_checks %0d num_errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_sim
	////////////////////////////////////////////////////////////////
	initial begin
		#3000000;
		num_errors++;
		end_sim();
	end
	initial begin
		rst_i = 1'b1;
		{reg_wr_i, reg_rd_i, start_press_i, stop_press_i, host_pending_i, host_op_done_i} = 6'h00;
		{reg_addr_i, reg_wdata_i, priority_sel_i, fdata, fail_set, rew_set} = '0;
		{host_selected_i, diag_enable_i, offline_set} = 3'b111;
		kid = 12'h236;
		repeat (4) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		rdchk(REG_STATUS, 12'hfff, 12'h000);
		for (int i = 0; i < 16; i++) wr(5'(i), 12'h0a5 + 12'(i * 273));
		for (int i = 0; i < 16; i++) rdchk(5'(i), 12'hfff, 12'h0a5 + 12'(i * 273));
		wr(5'h14, 12'hfff);
		rdchk(5'h14, 12'hfff, 12'h000);
		wr(5'h00, 12'h050);
		wr(5'h01, 12'h030);
		wr(5'h03, 12'h000);
		diag_enable_i <= 1'b0;
		step();
		chk(12'(load_cnt), 12'h000);
		rdchk(REG_STATUS, 12'h01f, 12'h000);
		diag_enable_i <= 1'b1;
		step();
		chk(12'(load_cnt), 12'h001); chk({4'h0, drive_addr_o}, 12'h003);
		rdchk(5'h02, 12'hfff, 12'h236);
		rdchk(REG_STATUS, 12'hfff, 12'h001);
		chk(maint_display_register_o, 12'h236);
		step();
		chk({4'h0, drive_addr_o}, 12'h005); chk(12'(exec_cnt), 12'h001);
		rdchk(REG_STATUS, 12'hfff, 12'h000);
		fail_set = 1'b1;
		fdata = 8'ha5;
		step();
		step();
		rdchk(REG_STATUS, 12'h006, 12'h006);
		rdchk(5'h03, 12'hfff, 12'ha50);
		host_selected_i <= 1'b0;
		repeat (6) @(posedge clk_sys_i);
		#1 chk({11'h000, busy_o}, 12'h000);
		host_selected_i <= 1'b1;
		press(1'b0);
		chk({11'h000, halt_ind_o}, 12'h000);
		wr(5'h03, 12'h001);
		rdchk(REG_STATUS, 12'h001, 12'h000);
		step();
		step();
		rdchk(REG_STATUS, 12'h007, 12'h003);
		fail_set = 1'b0;
		step();
		rdchk(REG_STATUS, 12'h007, 12'h001);
		wr(5'h03, 12'h003);
		#1 chk({11'h000, loop_test_o}, 12'h001);
		press(1'b1);
		chk({11'h000, halt_ind_o}, 12'h001);
		press(1'b0);
		wr(5'h03, 12'h000);
		offline_set = 1'b0;
		e = exec_cnt;
		step();
		chk(12'(exec_cnt), 12'(e));
		offline_set = 1'b1;
		step();
		rdchk(REG_STATUS, 12'h001, 12'h000);
		wr(5'h03, 12'h002);
		kid = 12'h247;
		step();
		chk(maint_display_register_o, 12'h247); chk(12'(exec_cnt), 12'(e + 1));
		wr(5'h03, 12'h246);
		kid = 12'h24a;
		step();
		chk(maint_display_register_o, 12'h24a); chk({11'h000, halt_ind_o}, 12'h001);
		press(1'b0);
		wr(5'h03, 12'h000);
		wr(5'h01, 12'h031);
		rew_set = 1'b1;
		step();
		step();
		chk(12'(rew_cnt), 12'h001);
		chk({11'h000, halt_ind_o}, 12'h000);
		wr(5'h01, 12'h030);
		step();
		step();
		chk(12'(rew_cnt), 12'h001);
		chk({11'h000, halt_ind_o}, 12'h001);
		rew_set = 1'b0;
		press(1'b0);
		@(posedge clk_sys_i);
		host_selected_i <= 1'b0;
		host_op_done_i <= 1'b1;
		@(posedge clk_sys_i);
		host_op_done_i <= 1'b0;
		repeat (12) @(posedge clk_sys_i);
		#1 chk({11'h000, busy_o}, 12'h000);
		wait_busy(1'b1, 20);
		wait_busy(1'b0, 80);
		host_selected_i <= 1'b1;
		// second switch position gives a much longer window
		priority_sel_i <= 2'd1;
		@(posedge clk_sys_i);
		host_selected_i <= 1'b0;
		host_op_done_i <= 1'b1;
		@(posedge clk_sys_i);
		host_op_done_i <= 1'b0;
		repeat (40) @(posedge clk_sys_i);
		#1 chk({11'h000, busy_o}, 12'h000);
		wait_busy(1'b1, 240);
		wait_busy(1'b0, 80);
		host_selected_i <= 1'b1;
		end_sim();
	end
endmodule : tb_diag_executive
